// ===== verilog/rio_cell.v
// Purpose: registered i/o cell joining array routing to one pad
// Assumes: CLOCK_IN is the i/o register clock, 10 MHz
// Notes: control over apb; pad pins split into in, out and enable
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ns
`include "rio_defines.vh"

// How it works
// RULE1: two d flip-flops, output and input path, both on the i/o clock.
// RULE2: each flip-flop can be bypassed by configuration for combinational i/o.
// RULE3: each flip-flop has its own data enable; loads only while enabled.
// RULE4: both flip-flops preset or clear asynchronously from the set/reset net.
// RULE5: a per-cell configuration bit chooses preset or clear.
// RULE6: array output carries the inbound value or the output register fed back.
// RULE7: the pad driver can go high-impedance under its output enable.
// RULE8: four links module-driver: drive enable, sense enable, data out, data in.
// RULE9: in test, chip-wide drive and sense enables plus per-pad slew apply.
// RULE10: temporary special pins are user i/o unless test mode is asserted.
// RULE11: permanent special role is fixed once configuration is locked.
// RULE12: pad released while not driving; inbound follows pad when sensing.
module rio_cell (
  input wire CLOCK_IN,
  input wire SRST_IN,
  // apb slave
  input wire PSEL_IN,
  input wire PENABLE_IN,
  input wire PWRITE_IN,
  input wire [`RIO_ADDR_W-1:0] PADDR_IN,
  input wire [31:0] PWDATA_IN,
  input wire [3:0] PSTRB_IN,
  output reg [31:0] PRDATA_OUT,
  output reg PREADY_OUT,
  output reg PSLVERR_OUT,
  // array side
  input wire ARRAY_DATA_IN,
  input wire ARRAY_DRIVE_ENABLE_IN,
  input wire PAD_SENSE_ENABLE_IN,
  input wire OUTBOUND_REG_DATA_ENABLE_IN,
  input wire INBOUND_REG_DATA_ENABLE_IN,
  output reg ARRAY_Y_OUT,
  // dedicated preset/clear network
  input wire IO_ASYNC_SET_RESET_NET_IN,
  // programming and test
  input wire TEST_MODE_IN,
  input wire CHIPWIDE_DRIVE_ENABLE_IN,
  input wire CHIPWIDE_SENSE_ENABLE_IN,
  input wire TEST_DATA_IN,
  output reg TEST_DATA_OUT,
  output reg SLEW_OUT,
  // pad
  input wire PAD_IN,
  output reg PAD_OUT,
  output reg PAD_OE_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  reg pad_meta_reg;
  reg pad_sync_reg;
  reg test_meta_reg;
  reg test_sync_reg;
  reg cw_drive_meta_reg;
  reg cw_drive_sync_reg;
  reg cw_sense_meta_reg;
  reg cw_sense_sync_reg;
  reg tdata_meta_reg;
  reg tdata_sync_reg;

  always @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      pad_meta_reg <= 1'b0;
      pad_sync_reg <= 1'b0;
      test_meta_reg <= 1'b0;
      test_sync_reg <= 1'b0;
      cw_drive_meta_reg <= 1'b0;
      cw_drive_sync_reg <= 1'b0;
      cw_sense_meta_reg <= 1'b0;
      cw_sense_sync_reg <= 1'b0;
      tdata_meta_reg <= 1'b0;
      tdata_sync_reg <= 1'b0;
    end else begin
      pad_meta_reg <= PAD_IN;
      pad_sync_reg <= pad_meta_reg;
      test_meta_reg <= TEST_MODE_IN;
      test_sync_reg <= test_meta_reg;
      cw_drive_meta_reg <= CHIPWIDE_DRIVE_ENABLE_IN;
      cw_drive_sync_reg <= cw_drive_meta_reg;
      cw_sense_meta_reg <= CHIPWIDE_SENSE_ENABLE_IN;
      cw_sense_sync_reg <= cw_sense_meta_reg;
      tdata_meta_reg <= TEST_DATA_IN;
      tdata_sync_reg <= tdata_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb register file

  reg [`RIO_CTRL_W-1:0] ctrl_reg;
  reg [`RIO_CTRL_W-1:0] ctrl_next;
  wire apb_setup;
  wire apb_access;
  wire apb_write;
  wire apb_read;
  wire ctrl_lane0_write;
  wire unmapped;
  wire hit_ctrl;
  wire hit_status;
  wire locked;
  wire [31:0] status_word;
  reg [31:0] rdata_next;

  assign apb_setup = PSEL_IN & ~PENABLE_IN;
  // a write lands only at the edge that completes the access cycle
  assign apb_access = PSEL_IN & PENABLE_IN & PREADY_OUT;
  assign apb_write = apb_access & PWRITE_IN;
  assign apb_read = apb_setup & ~PWRITE_IN;
  assign hit_ctrl = (PADDR_IN == `RIO_CTRL_ADDR);
  assign hit_status = (PADDR_IN == `RIO_STATUS_ADDR);
  assign ctrl_lane0_write = apb_write & hit_ctrl & PSTRB_IN[0];
  assign unmapped = ~hit_ctrl & ~hit_status;
  assign locked = ctrl_reg[`RIO_CTRL_LOCK];

  // role bits and lock freeze once the lock bit is set
  always @* begin
    ctrl_next = ctrl_reg;
    if (ctrl_lane0_write) begin
      ctrl_next[`RIO_CTRL_OUT_BYPASS] = PWDATA_IN[`RIO_CTRL_OUT_BYPASS];
      ctrl_next[`RIO_CTRL_IN_BYPASS] = PWDATA_IN[`RIO_CTRL_IN_BYPASS];
      ctrl_next[`RIO_CTRL_PRESET_SEL] = PWDATA_IN[`RIO_CTRL_PRESET_SEL];
      ctrl_next[`RIO_CTRL_Y_FEEDBACK] = PWDATA_IN[`RIO_CTRL_Y_FEEDBACK];
      ctrl_next[`RIO_CTRL_SLEW] = PWDATA_IN[`RIO_CTRL_SLEW];
      if (!locked) begin // RULE11
        ctrl_next[`RIO_CTRL_TEMP_SPECIAL] =
          PWDATA_IN[`RIO_CTRL_TEMP_SPECIAL];
        ctrl_next[`RIO_CTRL_PERM_SPECIAL] =
          PWDATA_IN[`RIO_CTRL_PERM_SPECIAL];
        ctrl_next[`RIO_CTRL_LOCK] = PWDATA_IN[`RIO_CTRL_LOCK];
      end
    end
  end

  always @* begin
    rdata_next = `RIO_ZERO32;
    if (apb_read & hit_ctrl) begin
      rdata_next[`RIO_CTRL_W-1:0] = ctrl_reg;
    end else if (apb_read & hit_status) begin
      rdata_next = status_word;
    end
  end

  // control register follows ctrl_next, which moves only on an access
  always @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      ctrl_reg <= `RIO_CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // zero wait states: ready rises in the access cycle
  always @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      PRDATA_OUT <= `RIO_ZERO32;
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
    end else begin
      PREADY_OUT <= apb_setup;
      PSLVERR_OUT <= apb_setup & unmapped;
      if (apb_setup) begin
        PRDATA_OUT <= rdata_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // i/o module: output path

  wire out_q;
  wire module_to_pad_value;
  wire temp_special_active;
  wire perm_special;

  // both flip-flops on the i/o clock, CLOCK_IN
  rio_io_reg u_out_reg ( // RULE1
    .clk_in(CLOCK_IN),
    .set_clr_net_in(IO_ASYNC_SET_RESET_NET_IN),
    .preset_sel_in(ctrl_reg[`RIO_CTRL_PRESET_SEL]),
    .bypass_in(ctrl_reg[`RIO_CTRL_OUT_BYPASS]),
    .enable_in(OUTBOUND_REG_DATA_ENABLE_IN),
    .d_in(ARRAY_DATA_IN),
    .q_out(out_q),
    .y_out(module_to_pad_value)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pad driver and role selection

  reg drive_enable;
  reg sense_enable;
  reg drv_data;
  wire pad_value;
  wire pad_drive;
  wire pad_to_module_value;

  assign perm_special = ctrl_reg[`RIO_CTRL_PERM_SPECIAL];
  // temporary special role only while test mode is asserted
  assign temp_special_active =
    ctrl_reg[`RIO_CTRL_TEMP_SPECIAL] & test_sync_reg; // RULE10

  always @* begin
    drive_enable = ARRAY_DRIVE_ENABLE_IN;
    sense_enable = PAD_SENSE_ENABLE_IN;
    drv_data = module_to_pad_value;
    if (perm_special) begin // RULE11
      drive_enable = 1'b0;
      sense_enable = 1'b1;
    end else if (temp_special_active) begin // RULE10
      drive_enable = 1'b1;
      sense_enable = 1'b1;
      drv_data = tdata_sync_reg;
    end
  end

  rio_pad_drv u_pad_drv ( // RULE8
    .oe_in(drive_enable),
    .ie_in(sense_enable),
    .module_to_pad_value_in(drv_data),
    .pad_level_in(pad_sync_reg),
    .test_mode_in(test_sync_reg),
    .chipwide_drive_enable_in(cw_drive_sync_reg),
    .chipwide_sense_enable_in(cw_sense_sync_reg),
    .pad_value_out(pad_value),
    .pad_drive_out(pad_drive),
    .pad_to_module_value_out(pad_to_module_value)
  );

  ////////////////////////////////////////////////////////////////////////////
  // i/o module: input path and array output

  wire in_q;
  wire inbound_value;
  wire y_value;
  wire test_sense_value;

  rio_io_reg u_in_reg ( // RULE1
    .clk_in(CLOCK_IN),
    .set_clr_net_in(IO_ASYNC_SET_RESET_NET_IN),
    .preset_sel_in(ctrl_reg[`RIO_CTRL_PRESET_SEL]),
    .bypass_in(ctrl_reg[`RIO_CTRL_IN_BYPASS]),
    .enable_in(INBOUND_REG_DATA_ENABLE_IN),
    .d_in(pad_to_module_value),
    .q_out(in_q),
    .y_out(inbound_value)
  );

  // feedback of the output register for state machines
  assign y_value = ctrl_reg[`RIO_CTRL_Y_FEEDBACK] ? out_q : inbound_value; // RULE6

  // sensed pad level reported only while the temporary role is active
  assign test_sense_value = temp_special_active & pad_to_module_value; // RULE10

  assign status_word = {26'h0000000,
                        locked,
                        test_sync_reg,
                        pad_drive,
                        in_q,
                        out_q,
                        pad_sync_reg};

  ////////////////////////////////////////////////////////////////////////////
  // registered top outputs

  always @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      PAD_OUT <= 1'b0;
      PAD_OE_OUT <= 1'b0;
      ARRAY_Y_OUT <= 1'b0;
      TEST_DATA_OUT <= 1'b0;
      SLEW_OUT <= 1'b0;
    end else begin
      PAD_OUT <= pad_value;
      PAD_OE_OUT <= pad_drive; // RULE7 RULE12
      ARRAY_Y_OUT <= y_value;
      TEST_DATA_OUT <= test_sense_value;
      SLEW_OUT <= ctrl_reg[`RIO_CTRL_SLEW]; // RULE9
    end
  end

endmodule // rio_cell

// ===== verilog/rio_defines.vh
// Purpose: constants for the registered I/O cell
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: definitions only
`ifndef RIO_DEFINES_VH
`define RIO_DEFINES_VH

// register byte addresses
`define RIO_ADDR_W 12
`define RIO_CTRL_ADDR 12'h000
`define RIO_STATUS_ADDR 12'h004

// control register fields
`define RIO_CTRL_W 8
`define RIO_CTRL_RESET 8'h00
`define RIO_CTRL_OUT_BYPASS 0
`define RIO_CTRL_IN_BYPASS 1
`define RIO_CTRL_PRESET_SEL 2
`define RIO_CTRL_Y_FEEDBACK 3
`define RIO_CTRL_TEMP_SPECIAL 4
`define RIO_CTRL_PERM_SPECIAL 5
`define RIO_CTRL_SLEW 6
`define RIO_CTRL_LOCK 7

// status register fields
`define RIO_STAT_PAD_LEVEL 0
`define RIO_STAT_OUT_Q 1
`define RIO_STAT_IN_Q 2
`define RIO_STAT_DRIVE 3
`define RIO_STAT_TEST_MODE 4
`define RIO_STAT_LOCKED 5

`define RIO_ZERO32 32'h00000000

`endif

// ===== verilog/rio_io_reg.v
// Purpose: one i/o flip-flop with data enable, bypass, async preset/clear
// Assumes: set_clr_net_in is a dedicated network, active high
// Notes: preset_sel_in picks whether the network presets or clears
`timescale 1ns/1ns

module rio_io_reg (
  input wire clk_in,
  input wire set_clr_net_in,
  input wire preset_sel_in,
  input wire bypass_in,
  input wire enable_in,
  input wire d_in,
  output wire q_out,
  output wire y_out
);

  wire preset;
  wire clear;
  reg q_reg;

  // per-module choice of preset or clear
  assign preset = set_clr_net_in & preset_sel_in; // RULE5
  assign clear = set_clr_net_in & ~preset_sel_in; // RULE5

  // loads on the clock edge only while enabled
  always @(posedge clk_in or posedge preset or posedge clear) begin // RULE4
    if (clear) begin
      q_reg <= 1'b0;
    end else if (preset) begin
      q_reg <= 1'b1;
    end else if (enable_in) begin // RULE3
      q_reg <= d_in;
    end
  end

  assign q_out = q_reg;
  assign y_out = bypass_in ? d_in : q_reg; // RULE2

endmodule // rio_io_reg

// ===== verilog/rio_pad_drv.v
// Purpose: pad driver between an i/o module and its pad
// Assumes: pad level already synchronised by the caller
// Notes: chip-wide enables only gate while test mode is active
`timescale 1ns/1ns

module rio_pad_drv (
  input wire oe_in,
  input wire ie_in,
  input wire module_to_pad_value_in,
  input wire pad_level_in,
  input wire test_mode_in,
  input wire chipwide_drive_enable_in,
  input wire chipwide_sense_enable_in,
  output wire pad_value_out,
  output wire pad_drive_out,
  output wire pad_to_module_value_out
);

  wire drive_gate;
  wire sense_gate;

  // chip-wide enables act only during programming and test
  assign drive_gate = ~test_mode_in | chipwide_drive_enable_in; // RULE9
  assign sense_gate = ~test_mode_in | chipwide_sense_enable_in; // RULE9

  // pad released when output enable is low
  assign pad_drive_out = oe_in & drive_gate; // RULE7 RULE12
  assign pad_value_out = module_to_pad_value_in;
  // input enable gates the pad onto the inbound line
  assign pad_to_module_value_out = ie_in & sense_gate & pad_level_in; // RULE8 RULE12

endmodule // rio_pad_drv

// ===== sim/rio_cell_monitor.sv
// Purpose: assertion checker for the registered i/o cell
// Assumes: sees rio_cell ports only; ctrl mirrored from apb writes
// Notes: bound to rio_cell below
`timescale 1ns/1ns
module rio_cell_monitor (
  input logic CLOCK_IN,
  input logic SRST_IN,
  input logic PSEL_IN,
  input logic PENABLE_IN,
  input logic PWRITE_IN,
  input logic [11:0] PADDR_IN,
  input logic [31:0] PWDATA_IN,
  input logic [3:0] PSTRB_IN,
  input logic PREADY_OUT,
  input logic ARRAY_DATA_IN,
  input logic ARRAY_DRIVE_ENABLE_IN,
  input logic PAD_SENSE_ENABLE_IN,
  input logic OUTBOUND_REG_DATA_ENABLE_IN,
  input logic IO_ASYNC_SET_RESET_NET_IN,
  input logic TEST_MODE_IN,
  input logic ARRAY_Y_OUT,
  input logic PAD_OUT,
  input logic PAD_OE_OUT
);
  logic [7:0] ctrl_q;
  logic [1:0] tm_cnt;
  logic calm;
  logic reg_ok;
  ////////////////////////////////////////////////////////////
  // mirror of ctrl and a count of cycles out of test mode
  always @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      ctrl_q <= 8'h00;
      tm_cnt <= 2'h0;
    end else begin
      if (PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN &&
          PSTRB_IN[0] && PADDR_IN == 12'h000)
        ctrl_q <= ctrl_q[7] ? {ctrl_q[7], PWDATA_IN[6], ctrl_q[5:4],
                               PWDATA_IN[3:0]} : PWDATA_IN[7:0];
      if (TEST_MODE_IN)
        tm_cnt <= 2'h0;
      else if (tm_cnt != 2'h3)
        tm_cnt <= tm_cnt + 2'h1;
    end
  end
  assign calm = tm_cnt == 2'h3 && ctrl_q[5:4] == 2'h0;
  assign reg_ok = calm && !ctrl_q[0] && ARRAY_DRIVE_ENABLE_IN &&
                  !IO_ASYNC_SET_RESET_NET_IN;
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (SRST_IN);
  a_apb_ready: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT)
    else $error("no ready in access cycle");
  a_out_bypass: assert property (
    calm && ctrl_q[0] && ARRAY_DRIVE_ENABLE_IN |=>
    PAD_OUT == $past(ARRAY_DATA_IN)) else $error("bypass path wrong");
  a_out_load: assert property (
    reg_ok && OUTBOUND_REG_DATA_ENABLE_IN ##1 reg_ok |=>
    PAD_OUT == $past(ARRAY_DATA_IN, 2)) else $error("out reg load wrong");
  a_out_hold: assert property (
    reg_ok && !OUTBOUND_REG_DATA_ENABLE_IN ##1 reg_ok |=> $stable(PAD_OUT))
    else $error("out reg changed while disabled");
  a_async_sel: assert property (
    calm && !ctrl_q[0] && ARRAY_DRIVE_ENABLE_IN &&
    IO_ASYNC_SET_RESET_NET_IN |=> PAD_OUT == $past(ctrl_q[2]))
    else $error("async preset or clear wrong");
  a_sense_gate: assert property (
    calm && ctrl_q[3:1] == 3'b001 && !PAD_SENSE_ENABLE_IN |=> !ARRAY_Y_OUT)
    else $error("inbound not gated by sense");
  a_y_feedback: assert property (
    reg_ok && ctrl_q[3] |=> ARRAY_Y_OUT == PAD_OUT)
    else $error("feedback differs from output reg");
  a_drive_off: assert property (
    calm && !ARRAY_DRIVE_ENABLE_IN |=> !PAD_OE_OUT)
    else $error("pad driven while disabled");
  a_perm_input: assert property (
    ctrl_q[5] && !ctrl_q[4] |=> !PAD_OE_OUT)
    else $error("dedicated input drives pad");
  c_bypass: cover property (calm && ctrl_q[0]);
  c_preset: cover property (IO_ASYNC_SET_RESET_NET_IN && ctrl_q[2]);
  c_lock: cover property (ctrl_q[7]);
endmodule // rio_cell_monitor

bind rio_cell rio_cell_monitor i_mon (.CLOCK_IN(CLOCK_IN), .SRST_IN(SRST_IN),
  .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN),
  .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .PSTRB_IN(PSTRB_IN),
  .PREADY_OUT(PREADY_OUT), .ARRAY_DATA_IN(ARRAY_DATA_IN),
  .ARRAY_DRIVE_ENABLE_IN(ARRAY_DRIVE_ENABLE_IN),
  .PAD_SENSE_ENABLE_IN(PAD_SENSE_ENABLE_IN),
  .OUTBOUND_REG_DATA_ENABLE_IN(OUTBOUND_REG_DATA_ENABLE_IN),
  .IO_ASYNC_SET_RESET_NET_IN(IO_ASYNC_SET_RESET_NET_IN),
  .TEST_MODE_IN(TEST_MODE_IN), .ARRAY_Y_OUT(ARRAY_Y_OUT),
  .PAD_OUT(PAD_OUT), .PAD_OE_OUT(PAD_OE_OUT));

// ===== sim/rio_pad_model.sv
// Purpose: off-chip pad with an optional external driver
// Assumes: pad has a pull-up when nobody drives it
// Notes: external driver must stay off while the cell drives
`timescale 1ns/1ns
module rio_pad_model (
  input logic drive_in,
  input logic drive_en_in,
  input logic ext_en_in,
  input logic ext_level_in,
  output logic pad_level_out
);
  // released pad floats to the pull-up level
  assign pad_level_out = drive_en_in ? drive_in :
                         (ext_en_in ? ext_level_in : 1'b1);
endmodule // rio_pad_model

// ===== sim/rio_cell_tb.sv
// Purpose: self-checking bench for the registered i/o cell
// Assumes: apb slave answers in one access cycle
// Notes: test pins driven in one scenario; pad modelled by rio_pad_model
`timescale 1ns/1ns
module rio_cell_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic pready, pslverr, err, y, tdo, slew, pad_o, pad_oe, pad_i;
  logic dat = 1'b0, den = 1'b0, sen = 1'b0, oen = 1'b0, ien = 1'b0;
  logic asr = 1'b0, ext_en = 1'b0, ext_lvl = 1'b0;
  logic tm = 1'b0, cwd = 1'b0, cws = 1'b0, tdi = 1'b0;
  logic [3:0] pstrb = 4'hf;
  integer n_errors = 0, n_compared = 0;
  always #50 clk = ~clk;
  rio_cell i_dut (.CLOCK_IN(clk), .SRST_IN(srst), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PSTRB_IN(pstrb), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .ARRAY_DATA_IN(dat),
    .ARRAY_DRIVE_ENABLE_IN(den), .PAD_SENSE_ENABLE_IN(sen),
    .OUTBOUND_REG_DATA_ENABLE_IN(oen), .INBOUND_REG_DATA_ENABLE_IN(ien),
    .ARRAY_Y_OUT(y), .IO_ASYNC_SET_RESET_NET_IN(asr),
    .TEST_MODE_IN(tm), .CHIPWIDE_DRIVE_ENABLE_IN(cwd),
    .CHIPWIDE_SENSE_ENABLE_IN(cws), .TEST_DATA_IN(tdi),
    .TEST_DATA_OUT(tdo), .SLEW_OUT(slew), .PAD_IN(pad_i),
    .PAD_OUT(pad_o), .PAD_OE_OUT(pad_oe));
  rio_pad_model i_pad (.drive_in(pad_o), .drive_en_in(pad_oe),
    .ext_en_in(ext_en), .ext_level_in(ext_lvl), .pad_level_out(pad_i));
  ////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    n_compared = n_compared + 1;
    if (seen !== ex) begin
      n_errors = n_errors + 1;
      $display("MISMATCH %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (3000) @(posedge clk);
    n_errors = n_errors + 1;
    wrap_up;
  end
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    den <= 1'b1;
    asr <= 1'b1;
    cyc(1);
    asr <= 1'b0;
    cyc(2);
    chk("clear", pad_o, 0);
    chk("drive", pad_oe, 1);
    apb(1, 12'h000, 32'h04);
    asr <= 1'b1;
    cyc(1);
    asr <= 1'b0;
    cyc(2);
    chk("preset", pad_o, 1);
    apb(0, 12'h000, 0);
    chk("ctrl", rd, 32'h04);
    apb(0, 12'h008, 0);
    chk("unmapped err", err, 1);
    $display("test async done");
    apb(1, 12'h000, 32'h00);
    cyc(3);
    chk("out hold", pad_o, 1);
    oen <= 1'b1;
    cyc(1);
    oen <= 1'b0;
    cyc(2);
    chk("out load", pad_o, 0);
    apb(1, 12'h000, 32'h01);
    dat <= 1'b1;
    cyc(2);
    chk("bypass", pad_o, 1);
    apb(0, 12'h004, 0);
    chk("out q", rd[1], 0);
    apb(1, 12'h000, 32'h08);
    oen <= 1'b1;
    cyc(1);
    oen <= 1'b0;
    cyc(2);
    chk("feedback", y, 1);
    $display("test output done");
    den <= 1'b0;
    sen <= 1'b1;
    apb(1, 12'h000, 32'h02);
    ext_en <= 1'b1;
    ext_lvl <= 1'b1;
    cyc(5);
    chk("released", pad_oe, 0);
    chk("sense on", y, 1);
    sen <= 1'b0;
    cyc(3);
    chk("sense off", y, 0);
    sen <= 1'b1;
    apb(1, 12'h000, 32'h00);
    ext_lvl <= 1'b0;
    cyc(6);
    chk("in hold", y, 1);
    ien <= 1'b1;
    cyc(4);
    chk("in load", y, 0);
    $display("test input done");
    ext_en <= 1'b0;
    den <= 1'b1;
    apb(1, 12'h000, 32'h10);
    chk("tmp user pad", pad_o, 1);
    chk("tmp user sense", tdo, 0);
    tm <= 1'b1;
    cwd <= 1'b1;
    cws <= 1'b1;
    cyc(4);
    chk("tmp test pad", pad_o, 0);
    tdi <= 1'b1;
    cyc(8);
    chk("tmp test sense", tdo, 1);
    cwd <= 1'b0;
    cyc(4);
    chk("chipwide drive", pad_oe, 0);
    cws <= 1'b0;
    cyc(4);
    chk("chipwide sense", tdo, 0);
    tm <= 1'b0;
    $display("test mode done");
    apb(1, 12'h000, 32'he0);
    cyc(1);
    chk("slew", slew, 1);
    apb(1, 12'h000, 32'h10);
    apb(0, 12'h000, 0);
    chk("locked", rd, 32'ha0);
    pstrb <= 4'h0;
    apb(1, 12'h000, 32'h41);
    pstrb <= 4'hf;
    apb(0, 12'h000, 0);
    chk("strobe off", rd, 32'ha0);
    chk("perm no drive", pad_oe, 0);
    $display("test lock done");
    wrap_up;
  end
endmodule // rio_cell_tb
